// ===== logic/iam_entry_match.sv
// One IPv6/ICMP access-control entry with APB configuration and hit output.
module iam_entry_match #(
  parameter int unsigned SRC_W = 32
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire iam_pkg::iam_addr_t PADDR,
  input wire iam_pkg::iam_word_t PWDATA,
  output iam_pkg::iam_word_t PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic FRM_VALID,
  input wire logic FRM_IPV6,
  input wire logic [7:0] FRM_NEXT_HDR,
  input wire logic [SRC_W-1:0] FRM_SRC_LOW,
  input wire logic [7:0] FRM_HOP_LIMIT,
  input wire logic [7:0] FRM_ICMP_TYPE,
  input wire logic [7:0] FRM_ICMP_CODE,
  output logic RES_VALID,
  output logic RES_HIT,
  output logic RES_ICMP_ACTIVE,
  output logic RES_UDP_ACTIVE,
  output logic RES_TCP_ACTIVE
);
  import iam_pkg::*;

  logic [CTRL_W-1:0] ctrl;
  logic [VAL_W-1:0] values;
  logic [SRC_W-1:0] src_value;
  logic [SRC_W-1:0] src_mask;
  logic [STAT_CNT_W-1:0] hit_count;
  logic last_hit;

  // Bus decode.
  logic access;
  logic first_access;
  logic done;
  logic sel_ctrl;
  logic sel_values;
  logic sel_src_value;
  logic sel_src_mask;
  logic sel_status;
  logic mapped;
  logic wr_done;
  iam_word_t rd_data;

  assign access = PSEL && PENABLE;
  assign first_access = access && !PREADY;
  assign done = access && PREADY;
  assign sel_ctrl = (PADDR == OFS_CTRL);
  assign sel_values = (PADDR == OFS_VALUES);
  assign sel_src_value = (PADDR == OFS_SRC_VALUE);
  assign sel_src_mask = (PADDR == OFS_SRC_MASK);
  assign sel_status = (PADDR == OFS_STATUS);
  assign mapped = sel_ctrl || sel_values || sel_src_value ||
    sel_src_mask || sel_status;
  assign wr_done = done && PWRITE && mapped;

  assign rd_data = sel_ctrl ? {{(DATA_W-CTRL_W){1'b0}}, ctrl} :
    sel_values ? {{(DATA_W-VAL_W){1'b0}}, values} :
    sel_src_value ? src_value :
    sel_src_mask ? src_mask :
    sel_status ? {15'h0000, last_hit, hit_count} :
    32'h00000000;

  // Configuration fields.
  logic [2:0] cfg_nh_mode;
  logic [1:0] cfg_hop_mode;
  logic cfg_src_specific;
  logic cfg_type_specific;
  logic cfg_code_specific;
  logic cfg_enable;
  logic [7:0] cfg_nh_value;
  logic [7:0] cfg_type_value;
  logic [7:0] cfg_code_value;

  assign cfg_nh_mode = ctrl[CTRL_NH_LSB +: CTRL_NH_W];
  assign cfg_hop_mode = ctrl[CTRL_HOP_LSB +: CTRL_HOP_W];
  assign cfg_src_specific = ctrl[CTRL_SRC_BIT];
  assign cfg_type_specific = ctrl[CTRL_TYPE_BIT];
  assign cfg_code_specific = ctrl[CTRL_CODE_BIT];
  assign cfg_enable = ctrl[CTRL_EN_BIT];
  assign cfg_nh_value = values[VAL_NH_LSB +: 8];
  assign cfg_type_value = values[VAL_TYPE_LSB +: 8];
  assign cfg_code_value = values[VAL_CODE_LSB +: 8];

  logic match;
  logic icmp_active;
  logic udp_active;
  logic tcp_active;

  iam_criteria #(
    .SRC_W(SRC_W)
  ) u_criteria (
    .nh_mode(cfg_nh_mode),
    .nh_value(cfg_nh_value),
    .src_specific(cfg_src_specific),
    .src_value(src_value),
    .src_mask(src_mask),
    .hop_mode(cfg_hop_mode),
    .type_specific(cfg_type_specific),
    .type_value(cfg_type_value),
    .code_specific(cfg_code_specific),
    .code_value(cfg_code_value),
    .frm_ipv6(FRM_IPV6),
    .frm_next_hdr(FRM_NEXT_HDR),
    .frm_src_low(FRM_SRC_LOW),
    .frm_hop_limit(FRM_HOP_LIMIT),
    .frm_icmp_type(FRM_ICMP_TYPE),
    .frm_icmp_code(FRM_ICMP_CODE),
    .match(match),
    .icmp_active(icmp_active),
    .udp_active(udp_active),
    .tcp_active(tcp_active)
  );

  logic next_hit;
  logic count_clear;
  logic [STAT_CNT_W-1:0] count_base;
  logic [STAT_CNT_W-1:0] next_count;

  assign next_hit = FRM_VALID && cfg_enable && match;
  assign count_clear = wr_done && sel_status;
  // A hit in the clearing cycle is still counted, so none is lost.
  assign count_base = count_clear ? '0 : hit_count;
  assign next_count = (next_hit && (count_base != '1)) ?
    count_base + 16'h0001 : count_base;

  // Bus answer: one wait state, then PREADY for one cycle.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY <= first_access;
      PRDATA <= (first_access && !PWRITE && mapped) ? rd_data : 32'h00000000;
      PSLVERR <= first_access && !mapped;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl <= CTRL_RESET;
      values <= VALUES_RESET;
      src_value <= SRC_VALUE_RESET;
      src_mask <= SRC_MASK_RESET;
    end else if (CE && wr_done) begin
      if (sel_ctrl) ctrl <= PWDATA[CTRL_W-1:0];
      if (sel_values) values <= PWDATA[VAL_W-1:0];
      if (sel_src_value) src_value <= PWDATA[SRC_W-1:0];
      if (sel_src_mask) src_mask <= PWDATA[SRC_W-1:0];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hit_count <= '0;
      last_hit <= 1'b0;
    end else if (CE) begin
      hit_count <= next_count;
      if (FRM_VALID) last_hit <= next_hit;
    end
  end

  // Result stage: one cycle after the frame fields are offered.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RES_VALID <= 1'b0;
      RES_HIT <= 1'b0;
      RES_ICMP_ACTIVE <= 1'b0;
      RES_UDP_ACTIVE <= 1'b0;
      RES_TCP_ACTIVE <= 1'b0;
    end else if (CE) begin
      RES_VALID <= FRM_VALID;
      RES_HIT <= next_hit;
      RES_ICMP_ACTIVE <= FRM_VALID && icmp_active;
      RES_UDP_ACTIVE <= FRM_VALID && udp_active;
      RES_TCP_ACTIVE <= FRM_VALID && tcp_active;
    end
  end

  // Checks on the hit decision and the bus answer.
  logic evt;
  assign evt = CE && FRM_VALID && FRM_IPV6 && cfg_enable;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  nh_any_a: assert property (
    evt && cfg_nh_mode == NH_ANY && !cfg_src_specific &&
    cfg_hop_mode == HOP_ANY |=> RES_HIT)
    else $error("Next-header any with all don't-care did not hit.");

  nh_specific_a: assert property (
    evt && cfg_nh_mode == NH_SPECIFIC && FRM_NEXT_HDR != cfg_nh_value
    |=> !RES_HIT)
    else $error("Next-header value mismatch still hit.");

  icmp_proto_a: assert property (
    evt && cfg_nh_mode == NH_ICMP && FRM_NEXT_HDR != PROTO_ICMPV6
    |=> !RES_HIT && RES_ICMP_ACTIVE)
    else $error("Non-ICMPv6 frame hit an ICMP entry.");

  udp_proto_a: assert property (
    evt && cfg_nh_mode == NH_UDP |=>
    RES_UDP_ACTIVE && (RES_HIT -> $past(FRM_NEXT_HDR) == PROTO_UDP))
    else $error("UDP entry hit a non-UDP frame.");

  tcp_proto_a: assert property (
    evt && cfg_nh_mode == NH_TCP |=>
    RES_TCP_ACTIVE && (RES_HIT -> $past(FRM_NEXT_HDR) == PROTO_TCP))
    else $error("TCP entry hit a non-TCP frame.");

  src_any_a: assert property (
    evt && !cfg_src_specific && cfg_hop_mode == HOP_ANY &&
    cfg_nh_mode == NH_SPECIFIC && FRM_NEXT_HDR == cfg_nh_value
    |=> RES_HIT)
    else $error("Source don't-care blocked a hit.");

  src_mask_a: assert property (
    evt && cfg_src_specific &&
    ((FRM_SRC_LOW ^ src_value) & src_mask) != '0 |=> !RES_HIT)
    else $error("Masked source mismatch still hit.");

  src_low_a: assert property (
    RES_HIT && $past(cfg_src_specific) |->
    (($past(FRM_SRC_LOW) ^ $past(src_value)) & $past(src_mask)) == '0)
    else $error("Hit with source low word outside the entry.");

  hop_zero_a: assert property (
    evt && ((cfg_hop_mode == HOP_ZERO && FRM_HOP_LIMIT != 8'h00) ||
    (cfg_hop_mode == HOP_NONZERO && FRM_HOP_LIMIT == 8'h00)) |=> !RES_HIT)
    else $error("Hop-limit condition violated by a hit.");

  icmp_any_a: assert property (
    evt && cfg_nh_mode == NH_ICMP && FRM_NEXT_HDR == PROTO_ICMPV6 &&
    !cfg_type_specific && !cfg_code_specific && !cfg_src_specific &&
    cfg_hop_mode == HOP_ANY |=> RES_HIT)
    else $error("ICMP don't-care type and code blocked a hit.");

  icmp_type_a: assert property (
    evt && cfg_nh_mode == NH_ICMP && cfg_type_specific &&
    FRM_ICMP_TYPE != cfg_type_value |=> !RES_HIT)
    else $error("ICMP type mismatch still hit.");

  icmp_code_a: assert property (
    evt && cfg_nh_mode == NH_ICMP && cfg_code_specific &&
    FRM_ICMP_CODE != cfg_code_value |=> !RES_HIT)
    else $error("ICMP code mismatch still hit.");

  hit_cause_a: assert property (
    RES_HIT |-> RES_VALID && $past(evt))
    else $error("Hit without an enabled IPv6 frame.");

  bus_answer_a: assert property (
    CE && first_access ##1 CE && access |-> PREADY ##1 !PREADY)
    else $error("Bus answer not a single cycle after one wait.");

  icmp_hit_c: cover property (
    evt && cfg_nh_mode == NH_ICMP && cfg_type_specific ##1 RES_HIT);
  mask_miss_c: cover property (
    evt && cfg_src_specific && src_mask != '1 ##1 RES_VALID && !RES_HIT);
  bus_write_c: cover property (CE && wr_done && sel_ctrl);
  bus_error_c: cover property (CE && PREADY && PSLVERR);

endmodule : iam_entry_match

// ===== logic/iam_pkg.sv
// Package with register map, field layout and codes of the entry matcher.
package iam_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  typedef logic [ADDR_W-1:0] iam_addr_t;
  typedef logic [DATA_W-1:0] iam_word_t;
  typedef logic [2:0] iam_nh_t;
  typedef logic [1:0] iam_hop_t;

  // Register byte offsets.
  localparam iam_addr_t OFS_CTRL = 8'h00;
  localparam iam_addr_t OFS_VALUES = 8'h04;
  localparam iam_addr_t OFS_SRC_VALUE = 8'h08;
  localparam iam_addr_t OFS_SRC_MASK = 8'h0C;
  localparam iam_addr_t OFS_STATUS = 8'h10;

  // Control register fields.
  localparam int unsigned CTRL_NH_LSB = 0;
  localparam int unsigned CTRL_NH_W = 3;
  localparam int unsigned CTRL_SRC_BIT = 3;
  localparam int unsigned CTRL_HOP_LSB = 4;
  localparam int unsigned CTRL_HOP_W = 2;
  localparam int unsigned CTRL_TYPE_BIT = 6;
  localparam int unsigned CTRL_CODE_BIT = 7;
  localparam int unsigned CTRL_EN_BIT = 8;
  localparam int unsigned CTRL_W = 9;

  // Value register fields, one byte each.
  localparam int unsigned VAL_NH_LSB = 0;
  localparam int unsigned VAL_TYPE_LSB = 8;
  localparam int unsigned VAL_CODE_LSB = 16;
  localparam int unsigned VAL_W = 24;

  // Status register fields.
  localparam int unsigned STAT_CNT_LSB = 0;
  localparam int unsigned STAT_CNT_W = 16;
  localparam int unsigned STAT_LAST_BIT = 16;

  // Reset values.
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;
  localparam logic [VAL_W-1:0] VALUES_RESET = 24'h000000;
  localparam iam_word_t SRC_VALUE_RESET = 32'h00000000;
  localparam iam_word_t SRC_MASK_RESET = 32'hFFFFFFFF;

  // Next-header filter modes.
  localparam iam_nh_t NH_ANY = 3'h0;
  localparam iam_nh_t NH_SPECIFIC = 3'h1;
  localparam iam_nh_t NH_ICMP = 3'h2;
  localparam iam_nh_t NH_UDP = 3'h3;
  localparam iam_nh_t NH_TCP = 3'h4;

  // Hop-limit condition settings.
  localparam iam_hop_t HOP_ANY = 2'h0;
  localparam iam_hop_t HOP_ZERO = 2'h1;
  localparam iam_hop_t HOP_NONZERO = 2'h2;

  // Protocol numbers carried in the IPv6 next-header byte.
  localparam logic [7:0] PROTO_ICMPV6 = 8'h3A;
  localparam logic [7:0] PROTO_UDP = 8'h11;
  localparam logic [7:0] PROTO_TCP = 8'h06;

endpackage : iam_pkg

// ===== logic/iam_criteria.sv
// Combinational test of one entry's criteria against parsed frame fields.
module iam_criteria #(
  parameter int unsigned SRC_W = 32
) (
  input wire logic [2:0] nh_mode,
  input wire logic [7:0] nh_value,
  input wire logic src_specific,
  input wire logic [SRC_W-1:0] src_value,
  input wire logic [SRC_W-1:0] src_mask,
  input wire logic [1:0] hop_mode,
  input wire logic type_specific,
  input wire logic [7:0] type_value,
  input wire logic code_specific,
  input wire logic [7:0] code_value,
  input wire logic frm_ipv6,
  input wire logic [7:0] frm_next_hdr,
  input wire logic [SRC_W-1:0] frm_src_low,
  input wire logic [7:0] frm_hop_limit,
  input wire logic [7:0] frm_icmp_type,
  input wire logic [7:0] frm_icmp_code,
  output logic match,
  output logic icmp_active,
  output logic udp_active,
  output logic tcp_active
);
  import iam_pkg::*;

  // A byte criterion left at don't-care always holds.
  function automatic logic byte_ok(input logic specific,
                                   input logic [7:0] want,
                                   input logic [7:0] seen);
    return !specific || (want == seen);
  endfunction : byte_ok

  logic nh_ok;
  logic src_ok;
  logic hop_ok;
  logic type_ok;
  logic code_ok;

  // Unused mode codes never match, so a bad setting cannot open the entry.
  assign nh_ok = (nh_mode == NH_ANY) ? 1'b1 :
    (nh_mode == NH_SPECIFIC) ? byte_ok(1'b1, nh_value, frm_next_hdr) :
    (nh_mode == NH_ICMP) ? byte_ok(1'b1, PROTO_ICMPV6, frm_next_hdr) :
    (nh_mode == NH_UDP) ? byte_ok(1'b1, PROTO_UDP, frm_next_hdr) :
    (nh_mode == NH_TCP) ? byte_ok(1'b1, PROTO_TCP, frm_next_hdr) :
    1'b0;

  assign icmp_active = (nh_mode == NH_ICMP);
  assign udp_active = (nh_mode == NH_UDP);
  assign tcp_active = (nh_mode == NH_TCP);

  // Only the low word of the address is stored; a zero mask bit is ignored.
  assign src_ok = !src_specific ||
    (((frm_src_low ^ src_value) & src_mask) == '0);

  assign hop_ok = (hop_mode == HOP_ANY) ||
    ((hop_mode == HOP_ZERO) && (frm_hop_limit == 8'h00)) ||
    ((hop_mode == HOP_NONZERO) && (frm_hop_limit != 8'h00));

  assign type_ok = !icmp_active ||
    byte_ok(type_specific, type_value, frm_icmp_type);
  assign code_ok = !icmp_active ||
    byte_ok(code_specific, code_value, frm_icmp_code);

  assign match = frm_ipv6 && nh_ok && src_ok && hop_ok &&
    type_ok && code_ok;

endmodule : iam_criteria

// ===== tb/iam_frame_src.sv
// Stand-in for the ingress parser that presents one parsed frame per request.
module iam_frame_src (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic [64:0] fld,
  output logic frm_valid,
  output logic [64:0] frm
);
  timeunit 1ns;
  timeprecision 1ns;
  // Between frames the fields toggle every cycle, so stale data cannot hit.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frm_valid <= 1'b0;
      frm <= 65'h0;
    end else begin
      frm_valid <= req;
      frm <= req ? fld : ~frm;
    end
  end
endmodule : iam_frame_src

// ===== tb/tb.sv
// Self-checking testbench for the IPv6 and ICMP entry matcher.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import iam_pkg::*;
  logic CLK, RST, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, req;
  iam_addr_t PADDR;
  iam_word_t PWDATA, PRDATA, q;
  logic FRM_VALID, FRM_IPV6, RES_VALID, RES_HIT, e;
  logic [7:0] FRM_NEXT_HDR, FRM_HOP_LIMIT, FRM_ICMP_TYPE, FRM_ICMP_CODE;
  logic [31:0] FRM_SRC_LOW;
  logic RES_ICMP_ACTIVE, RES_UDP_ACTIVE, RES_TCP_ACTIVE;
  logic [64:0] fld, frm;
  int n_mismatch, tests_run;
  assign {FRM_IPV6, FRM_NEXT_HDR, FRM_SRC_LOW, FRM_HOP_LIMIT} = frm[64:16];
  assign {FRM_ICMP_TYPE, FRM_ICMP_CODE} = frm[15:0];

  iam_entry_match DUT (.CLK, .RST, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .FRM_VALID, .FRM_IPV6,
    .FRM_NEXT_HDR, .FRM_SRC_LOW, .FRM_HOP_LIMIT, .FRM_ICMP_TYPE,
    .FRM_ICMP_CODE, .RES_VALID, .RES_HIT, .RES_ICMP_ACTIVE,
    .RES_UDP_ACTIVE, .RES_TCP_ACTIVE);
  iam_frame_src parser (.clk(CLK), .rst(RST), .req(req), .fld(fld),
    .frm_valid(FRM_VALID), .frm(frm));

  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; the idle edge at entry keeps back-to-back calls legal.
  task automatic apb(logic wr, iam_addr_t a, iam_word_t d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // Answer is taken at the edge that samples ready high; a hang is left
    // to the watchdog, so no wait-state count is assumed here.
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic rd(iam_addr_t a, iam_word_t exp);
    apb(1'b0, a, 32'h0);
    chk("read data", q, exp);
  endtask : rd

  function automatic iam_word_t cf(iam_nh_t nh, logic s, iam_hop_t h,
                                   logic t, logic c);
    return {23'h0, 1'b1, c, t, h, s, nh};
  endfunction : cf

  function automatic logic [64:0] fr(logic [7:0] nh, logic [31:0] s,
                                     logic [7:0] h, logic [15:0] tc);
    return {1'b1, nh, s, h, tc};
  endfunction : fr

  // Expected nibble is hit, then the ICMP, UDP and TCP activity flags.
  task automatic send(logic [64:0] f, logic [3:0] exp);
    @(posedge CLK);
    req <= 1'b1;
    fld <= f;
    @(posedge CLK);
    req <= 1'b0;
    @(posedge CLK);
    #1;
    chk("result", {RES_VALID, RES_HIT, RES_ICMP_ACTIVE, RES_UDP_ACTIVE,
        RES_TCP_ACTIVE}, {1'b1, exp});
  endtask : send

  task automatic t_regs();
    rd(OFS_CTRL, 32'h00000000);
    rd(OFS_SRC_MASK, 32'hFFFFFFFF);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped data", q, 32'h00000000);
    chk("unmapped error", {31'h0, e}, 32'h00000001);
    $display("register test done");
  endtask : t_regs

  task automatic t_status();
    apb(1'b1, OFS_STATUS, 32'h0);
    send(fr(8'h3A, 32'h0, 8'h40, 16'h80FF), 4'hC);
    rd(OFS_STATUS, 32'h00010001);
    send(fr(8'h3A, 32'h0, 8'h40, 16'h81FF), 4'h4);
    rd(OFS_STATUS, 32'h00000001);
    $display("status test done");
  endtask : t_status

  task automatic t_nh();
    logic [7:0] pr [3] = '{PROTO_ICMPV6, PROTO_UDP, PROTO_TCP};
    apb(1'b1, OFS_CTRL, cf(NH_ANY, 1'b0, HOP_ANY, 1'b0, 1'b0));
    send(fr(8'h99, 32'h0, 8'h40, 16'h0), 4'h8);
    send(fr(8'h99, 32'h0, 8'h40, 16'h0) ^ {1'b1, 64'h0}, 4'h0);
    apb(1'b1, OFS_VALUES, 32'h0000002B);
    apb(1'b1, OFS_CTRL, cf(NH_SPECIFIC, 1'b0, HOP_ANY, 1'b0, 1'b0));
    send(fr(8'h2B, 32'h0, 8'h40, 16'h0), 4'h8);
    send(fr(8'h2C, 32'h0, 8'h40, 16'h0), 4'h0);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFS_CTRL,
          cf(iam_nh_t'(NH_ICMP + i), 1'b0, HOP_ANY, 1'b0, 1'b0));
      send(fr(pr[i], 32'h0, 8'h40, 16'h0), 4'h8 | (4'h4 >> i));
      send(fr(pr[(i + 1) % 3], 32'h0, 8'h40, 16'h0), 4'h4 >> i);
    end
    $display("next header test done");
  endtask : t_nh

  task automatic t_src();
    apb(1'b1, OFS_SRC_VALUE, 32'h00000003);
    apb(1'b1, OFS_SRC_MASK, 32'hFFFFFFFE);
    apb(1'b1, OFS_CTRL, cf(NH_ANY, 1'b1, HOP_ANY, 1'b0, 1'b0));
    send(fr(8'h06, 32'h00000002, 8'h40, 16'h0), 4'h8);
    send(fr(8'h06, 32'h00000003, 8'h40, 16'h0), 4'h8);
    send(fr(8'h06, 32'h00000001, 8'h40, 16'h0), 4'h0);
    send(fr(8'h06, 32'h80000003, 8'h40, 16'h0), 4'h0);
    apb(1'b1, OFS_CTRL, cf(NH_ANY, 1'b0, HOP_ANY, 1'b0, 1'b0));
    send(fr(8'h06, 32'h80000001, 8'h40, 16'h0), 4'h8);
    $display("source test done");
  endtask : t_src

  task automatic t_hop();
    iam_hop_t hm [3] = '{HOP_ZERO, HOP_NONZERO, HOP_ANY};
    logic [1:0] ex [3] = '{2'b10, 2'b01, 2'b11};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFS_CTRL, cf(NH_ANY, 1'b0, hm[i], 1'b0, 1'b0));
      send(fr(8'h11, 32'h0, 8'h00, 16'h0), {ex[i][1], 3'h0});
      send(fr(8'h11, 32'h0, 8'h01, 16'h0), {ex[i][0], 3'h0});
    end
    $display("hop limit test done");
  endtask : t_hop

  task automatic t_icmp();
    apb(1'b1, OFS_VALUES, 32'h0000803A);
    apb(1'b1, OFS_CTRL, cf(NH_ICMP, 1'b0, HOP_ANY, 1'b1, 1'b1));
    send(fr(8'h3A, 32'h0, 8'h40, 16'h8000), 4'hC);
    send(fr(8'h3A, 32'h0, 8'h40, 16'h8100), 4'h4);
    send(fr(8'h3A, 32'h0, 8'h40, 16'h8001), 4'h4);
    apb(1'b1, OFS_CTRL, cf(NH_ICMP, 1'b0, HOP_ANY, 1'b0, 1'b1));
    send(fr(8'h3A, 32'h0, 8'h40, 16'h5500), 4'hC);
    send(fr(8'h3A, 32'h0, 8'h40, 16'h55FF), 4'h4);
    apb(1'b1, OFS_CTRL, cf(NH_ICMP, 1'b0, HOP_ANY, 1'b1, 1'b0));
    send(fr(8'h3A, 32'h0, 8'h40, 16'h80FF), 4'hC);
    send(fr(8'h3A, 32'h0, 8'h40, 16'h81FF), 4'h4);
    $display("icmp test done");
  endtask : t_icmp

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #2000000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    {RST, CE, PSEL, PENABLE, PWRITE, req} = 6'b110000;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    fld = 65'h0;
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    t_regs();
    t_nh();
    t_src();
    t_hop();
    t_icmp();
    t_status();
    print_verdict();
  end
endmodule : tb
